// ===== verilog/adcst_status.sv
// adc status byte with write-to-clear of the conversion-done pending flag
module adcst_status (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // host i/o
   input wire adcst_pkg::adcst_io_t i_io,
   output logic [7:0] o_rdata,
   output logic o_rvalid,
   // acquisition engine
   input wire adcst_pkg::adcst_engine_t i_eng,
   input wire logic i_avg_en,
   input wire logic i_status_layout_select,
   // jumper pins
   input wire logic i_polarity_jumper,
   input wire logic i_wiring_jumper,
   input wire logic i_fifo_superset_jumper,
   // status outputs
   output logic o_overrun,
   output logic o_acq_reset_busy
);
   import adcst_pkg::*;

   function automatic logic hit(input adcst_io_t io, input logic [3:0] off);
      hit = (io.addr == off);
   endfunction

   logic pol_sync;
   logic wir_sync;
   logic fss_sync;
   logic acq_busy;
   logic chan_wr;
   logic stat_wr;
   logic conversion_done_pending;
   logic next_conversion_done_pending;
   logic [3:0] next_channel_index;
   logic [3:0] next_next_channel_index;
   logic [7:0] next_rdata;
   logic next_rvalid;
   logic next_overrun;
   logic next_acq_reset_busy;
   logic conversion_active;
   logic [7:0] status_byte;

   adcst_sync u_sync_pol (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_level(i_polarity_jumper),
      .o_level(pol_sync)
   );
   adcst_sync u_sync_wir (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_level(i_wiring_jumper),
      .o_level(wir_sync)
   );
   adcst_sync u_sync_fss (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_level(i_fifo_superset_jumper),
      .o_level(fss_sync)
   );

   assign chan_wr = i_io.wr && hit(i_io, ADCST_CHANNEL_OFFSET);
   assign stat_wr = i_io.wr && hit(i_io, ADCST_STATUS_OFFSET);

   adcst_acq_reset u_acq_reset (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_start(chan_wr),
      .i_avg_en(i_avg_en),
      .o_busy(acq_busy)
   );

   assign conversion_active = i_eng.conv_busy || i_eng.scan_busy || acq_busy;

   always_comb begin
      // byte seen by the host one cycle after a status read
      status_byte[ADCST_BIT_CNV] = conversion_active;
      status_byte[ADCST_BIT_POL] = pol_sync;
      status_byte[ADCST_BIT_WIR] = wir_sync;
      status_byte[ADCST_BIT_DONE] = conversion_done_pending;
      if (i_status_layout_select) begin
         status_byte[3:0] = {i_eng.trigger_activity_config_bit, i_eng.fifo_irq,
                             i_eng.irq_src_b, i_eng.irq_src_a};
      end else begin
         status_byte[3:0] = next_channel_index;
      end
   end

   always_comb begin
      next_conversion_done_pending = conversion_done_pending;
      next_next_channel_index = next_channel_index;
      next_rdata = o_rdata;
      next_rvalid = 1'b0;
      next_overrun = 1'b0;
      next_acq_reset_busy = conversion_active;
      // completion is recorded with no interrupt enable in the path
      if (stat_wr) begin
         next_conversion_done_pending = 1'b0;
      end
      if (i_eng.conv_done) begin
         next_conversion_done_pending = 1'b1;
      end
      // a pending flag never holds back the trigger schedule
      if (i_eng.trigger) begin
         next_overrun = fss_sync ? i_eng.fifo_full_flag : conversion_done_pending;
      end
      if (chan_wr) begin
         next_next_channel_index = i_io.wdata_ch;
      end else if (i_eng.trigger) begin
         next_next_channel_index = next_channel_index + 4'h1;
      end
      if (i_io.rd && hit(i_io, ADCST_STATUS_OFFSET)) begin
         next_rdata = status_byte;
         next_rvalid = 1'b1;
      end
      if (!i_resetn) begin
         next_conversion_done_pending = 1'b0;
         next_next_channel_index = ADCST_CH_RESET;
         next_rdata = ADCST_BYTE_RESET;
         next_rvalid = 1'b0;
         next_overrun = 1'b0;
         next_acq_reset_busy = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      conversion_done_pending <= next_conversion_done_pending;
      next_channel_index <= next_next_channel_index;
      o_rdata <= next_rdata;
      o_rvalid <= next_rvalid;
      o_overrun <= next_overrun;
      o_acq_reset_busy <= next_acq_reset_busy;
   end

   // checking helper: length of the acquisition reset now running
   // a channel write restarts the timer, so the count starts over on every write
   logic [ADCST_CNT_W:0] busy_run;
   logic [ADCST_CNT_W:0] next_busy_run;

   always_comb begin
      next_busy_run = busy_run;
      if (chan_wr || !acq_busy) begin
         next_busy_run = '0;
      end else if (busy_run != '1) begin
         // saturate rather than wrap, so a stuck timer cannot look short
         next_busy_run = busy_run + 1'b1;
      end
      if (!i_resetn) begin
         next_busy_run = '0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      busy_run <= next_busy_run;
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);

   a_done_sets: assert property (i_eng.conv_done |=> conversion_done_pending)
      else $error("done flag not set");
   a_clear_works: assert property (stat_wr && !i_eng.conv_done |=> !conversion_done_pending)
      else $error("status write did not clear");
   a_chan_rst_busy: assert property (chan_wr |=> acq_busy [*8])
      else $error("acquisition reset too short");
   a_rst_bounded: assert property ($rose(acq_busy) && !i_avg_en && !chan_wr |-> ##[1:45] !acq_busy)
      else $error("acquisition reset too long");
   a_busy_bit: assert property (i_io.rd && hit(i_io, ADCST_STATUS_OFFSET) |=> o_rdata[7] == $past(conversion_active))
      else $error("busy bit wrong");
   a_ch_advance: assert property (i_eng.trigger && !chan_wr |=> next_channel_index == $past(next_channel_index) + 4'h1)
      else $error("channel did not advance");
   a_low_alt: assert property (i_io.rd && i_status_layout_select && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[3:0] == $past({i_eng.trigger_activity_config_bit, i_eng.fifo_irq, i_eng.irq_src_b,
      i_eng.irq_src_a}))
      else $error("alternate layout wrong");
   a_low_default: assert property (i_io.rd && !i_status_layout_select && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[3:0] == $past(next_channel_index))
      else $error("channel nibble wrong");
   a_fifo_overrun: assert property (i_eng.trigger && fss_sync |=> o_overrun == $past(i_eng.fifo_full_flag))
      else $error("fifo overrun wrong");
   a_pol_bit: assert property (i_io.rd && hit(i_io, ADCST_STATUS_OFFSET) |=> o_rdata[6] == $past(pol_sync))
      else $error("polarity bit wrong");
   a_wir_bit: assert property (i_io.rd && hit(i_io, ADCST_STATUS_OFFSET) |=> o_rdata[5] == $past(wir_sync))
      else $error("wiring bit wrong");

   // reset values must hold while reset is low, so these are not disabled by it
   a_rst_values: assert property (disable iff (1'b0) !i_resetn
      |=> !conversion_done_pending && !acq_busy)
      else $error("pending or busy not cleared by reset");
   a_rst_index: assert property (disable iff (1'b0) !i_resetn
      |=> next_channel_index == ADCST_CH_RESET)
      else $error("channel index not cleared by reset");
   a_rst_outputs: assert property (disable iff (1'b0) !i_resetn
      |=> o_rdata == ADCST_BYTE_RESET && !o_rvalid && !o_overrun && !o_acq_reset_busy)
      else $error("outputs not cleared by reset");

   // host read answer: one pulse per status read, data held between reads
   a_rvalid_read: assert property (i_io.rd && hit(i_io, ADCST_STATUS_OFFSET) |=> o_rvalid)
      else $error("no answer to a status read");
   a_rvalid_other: assert property (!(i_io.rd && hit(i_io, ADCST_STATUS_OFFSET)) |=> !o_rvalid)
      else $error("answer without a status read");
   a_rdata_hold: assert property (!(i_io.rd && hit(i_io, ADCST_STATUS_OFFSET)) |=> $stable(o_rdata))
      else $error("read data changed without a read");
   a_done_bit: assert property (i_io.rd && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[ADCST_BIT_DONE] == $past(conversion_done_pending))
      else $error("done bit wrong");

   // alternate low nibble, one bit per source
   a_trg_bit: assert property (i_io.rd && i_status_layout_select && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[3] == $past(i_eng.trigger_activity_config_bit))
      else $error("trigger mirror bit wrong");
   a_fifo_irq_bit: assert property (i_io.rd && i_status_layout_select && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[2] == $past(i_eng.fifo_irq))
      else $error("fifo interrupt bit wrong");
   a_src_b_bit: assert property (i_io.rd && i_status_layout_select && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[1] == $past(i_eng.irq_src_b))
      else $error("source b bit wrong");
   a_src_a_bit: assert property (i_io.rd && i_status_layout_select && hit(i_io, ADCST_STATUS_OFFSET)
      |=> o_rdata[0] == $past(i_eng.irq_src_a))
      else $error("source a bit wrong");

   // pending flag: only completion sets it, only a status write or reset clears it
   a_done_hold: assert property (!i_eng.conv_done && !stat_wr |=> $stable(conversion_done_pending))
      else $error("done flag moved without cause");
   a_set_wins: assert property (stat_wr && i_eng.conv_done |=> conversion_done_pending)
      else $error("clear beat a completion");
   a_clear_other_offset: assert property (i_io.wr && !hit(i_io, ADCST_STATUS_OFFSET)
      && conversion_done_pending |=> conversion_done_pending)
      else $error("write elsewhere cleared the done flag");

   // channel index: loaded by a write, stepped by a trigger, held otherwise
   a_ch_load: assert property (chan_wr |=> next_channel_index == $past(i_io.wdata_ch))
      else $error("channel write not loaded");
   a_ch_hold: assert property (!chan_wr && !i_eng.trigger |=> $stable(next_channel_index))
      else $error("channel moved without cause");
   a_ch_wrap: assert property (i_eng.trigger && !chan_wr && next_channel_index == 4'hF
      |=> next_channel_index == ADCST_CH_RESET)
      else $error("channel did not wrap");

   // overrun: a pulse only after a trigger, cause chosen by the fifo jumper
   a_plain_overrun: assert property (i_eng.trigger && !fss_sync
      |=> o_overrun == $past(conversion_done_pending))
      else $error("plain overrun wrong");
   a_fifo_no_overrun: assert property (i_eng.trigger && fss_sync && !i_eng.fifo_full_flag |=> !o_overrun)
      else $error("overrun with fifo not full");
   a_no_trig_overrun: assert property (!i_eng.trigger |=> !o_overrun)
      else $error("overrun without a trigger");

   // busy level and its registered copy
   a_busy_mirror: assert property (1'b1 |=> o_acq_reset_busy == $past(conversion_active))
      else $error("busy output does not follow busy bit");
   a_busy_engine: assert property (i_eng.conv_busy || i_eng.scan_busy |=> o_acq_reset_busy)
      else $error("engine activity not shown as busy");
   a_busy_idle: assert property (!i_eng.conv_busy && !i_eng.scan_busy && !acq_busy
      |=> !o_acq_reset_busy)
      else $error("busy shown while idle");
   a_chan_busy: assert property (chan_wr |=> conversion_active)
      else $error("channel write did not raise busy");

   // acquisition reset length, counted by the helper above
   a_rst_short_len: assert property (acq_busy && !i_avg_en |-> busy_run < ADCST_ACQ_RST_CYC)
      else $error("acquisition reset overstayed");
   a_rst_short_end: assert property ($fell(acq_busy) && $past(i_resetn) && !$past(i_avg_en)
      |-> busy_run == ADCST_ACQ_RST_CYC)
      else $error("acquisition reset length wrong");
   a_rst_avg_len: assert property (acq_busy && i_avg_en |-> busy_run < ADCST_ACQ_RST_AVG_CYC)
      else $error("filtered acquisition reset overstayed");
   a_rst_avg_end: assert property ($fell(acq_busy) && $past(i_resetn) && $past(i_avg_en)
      |-> busy_run == ADCST_ACQ_RST_AVG_CYC)
      else $error("filtered acquisition reset length wrong");
   a_rst_avg_bounded: assert property ($rose(acq_busy) && i_avg_en && !chan_wr |-> ##[1:405] !acq_busy)
      else $error("filtered acquisition reset too long");

   // jumper levels arrive two cycles late through the synchronisers
   a_pol_sync: assert property (1'b1 |=> ##1 pol_sync == $past(i_polarity_jumper, 2))
      else $error("polarity jumper lag wrong");
   a_wir_sync: assert property (1'b1 |=> ##1 wir_sync == $past(i_wiring_jumper, 2))
      else $error("wiring jumper lag wrong");
   a_fss_sync: assert property (1'b1 |=> ##1 fss_sync == $past(i_fifo_superset_jumper, 2))
      else $error("fifo jumper lag wrong");

   c_clear_set: cover property (stat_wr && i_eng.conv_done);
   c_chan_write: cover property (chan_wr ##1 acq_busy [*3]);
   c_overrun: cover property (o_overrun);
   c_alt_read: cover property (i_io.rd && i_status_layout_select);
   c_avg_reset: cover property (chan_wr && i_avg_en);
endmodule

// ===== inc/adcst_pkg.sv
// package of constants and carrier types for the adc status byte
package adcst_pkg;
   localparam logic [3:0] ADCST_STATUS_OFFSET = 4'h8;
   localparam logic [3:0] ADCST_CHANNEL_OFFSET = 4'h2;
   localparam int ADCST_CLK_HZ = 40000000;
   localparam int ADCST_ACQ_RST_NS = 1000;
   localparam int ADCST_ACQ_RST_AVG_NS = 10000;
   // longest times, rounded down
   localparam int ADCST_ACQ_RST_CYC = ADCST_ACQ_RST_NS / (1000000000 / ADCST_CLK_HZ);
   localparam int ADCST_ACQ_RST_AVG_CYC = ADCST_ACQ_RST_AVG_NS / (1000000000 / ADCST_CLK_HZ);
   localparam int ADCST_CNT_W = 9;
   localparam int ADCST_BIT_CNV = 7;
   localparam int ADCST_BIT_POL = 6;
   localparam int ADCST_BIT_WIR = 5;
   localparam int ADCST_BIT_DONE = 4;
   localparam logic [3:0] ADCST_CH_RESET = 4'h0;
   localparam logic [7:0] ADCST_BYTE_RESET = 8'h00;

   // host i/o cycle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [3:0] wdata_ch;
   } adcst_io_t;

   // state from the acquisition engine
   typedef struct packed {
      logic conv_busy;
      logic scan_busy;
      logic conv_done;
      logic trigger;
      logic trigger_activity_config_bit;
      logic fifo_irq;
      logic irq_src_b;
      logic irq_src_a;
      logic fifo_full_flag;
   } adcst_engine_t;

   typedef enum logic [1:0] {
      ADCST_IDLE = 2'b00,
      ADCST_RST = 2'b01
   } adcst_state_t;
endpackage

// ===== verilog/adcst_sync.sv
// two-flop synchroniser for jumper levels
module adcst_sync (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // level in and out
   input wire logic i_level,
   output logic o_level
);
   logic stage1;
   logic stage2;
   logic next_stage1;
   logic next_stage2;
   always_comb begin
      next_stage1 = i_resetn ? i_level : 1'b0;
      next_stage2 = i_resetn ? stage1 : 1'b0;
   end
   always_ff @(posedge i_sys_clk) begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
   end
   assign o_level = stage2;
endmodule

// ===== verilog/adcst_acq_reset.sv
// acquisition reset timer started by a channel write
module adcst_acq_reset (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_resetn,
   // control
   input wire logic i_start,
   input wire logic i_avg_en,
   output logic o_busy
);
   import adcst_pkg::*;
   adcst_state_t state;
   adcst_state_t next_state;
   logic [ADCST_CNT_W-1:0] count;
   logic [ADCST_CNT_W-1:0] next_count;
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         ADCST_IDLE: begin
            if (i_start) begin
               next_state = ADCST_RST;
               next_count = i_avg_en ? ADCST_CNT_W'(ADCST_ACQ_RST_AVG_CYC - 1) : ADCST_CNT_W'(ADCST_ACQ_RST_CYC - 1);
            end
         end
         ADCST_RST: begin
            // a fresh write restarts the timer
            if (i_start) begin
               next_count = i_avg_en ? ADCST_CNT_W'(ADCST_ACQ_RST_AVG_CYC - 1) : ADCST_CNT_W'(ADCST_ACQ_RST_CYC - 1);
            end else if (count == '0) begin
               next_state = ADCST_IDLE;
            end else begin
               next_count = count - 1'b1;
            end
         end
         default: next_state = ADCST_IDLE;
      endcase
      if (!i_resetn) begin
         next_state = ADCST_IDLE;
         next_count = '0;
      end
   end
   always_ff @(posedge i_sys_clk) begin
      state <= next_state;
      count <= next_count;
   end
   assign o_busy = (state == ADCST_RST);
endmodule

// ===== test/adcst_host_model.sv
// host side model that issues status reads, clears and channel writes
module adcst_host_model (
   // clock
   input wire logic i_sys_clk,
   // host i/o cycle
   output adcst_pkg::adcst_io_t o_io,
   input wire logic [7:0] i_rdata,
   input wire logic i_rvalid
);
   timeunit 1ns;
   timeprecision 1ps;
   import adcst_pkg::*;

   initial begin
      o_io = '0;
   end

   // one read strobe; data is taken once the registered answer has settled
   task automatic read(input logic [3:0] a, output logic [7:0] d, output logic v);
      @(posedge i_sys_clk);
      o_io.rd <= 1'b1;
      o_io.addr <= a;
      @(posedge i_sys_clk);
      o_io.rd <= 1'b0;
      o_io.addr <= ~a;
      #1;
      d = i_rdata;
      v = i_rvalid;
   endtask

   // a write to the status offset clears the conversion-done pending flag whatever the data
   task automatic write(input logic [3:0] a, input logic [3:0] data);
      @(posedge i_sys_clk);
      o_io.wr <= 1'b1;
      o_io.addr <= a;
      o_io.wdata_ch <= data;
      @(posedge i_sys_clk);
      o_io.wr <= 1'b0;
      o_io.addr <= ~a;
      o_io.wdata_ch <= ~data;
   endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the adc status byte
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import adcst_pkg::*;

   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   adcst_io_t io;
   adcst_engine_t eng = '0;
   logic avg_en = 1'b0;
   logic layout = 1'b0;
   logic pol = 1'b1;
   logic wir = 1'b0;
   logic fifo_jmp = 1'b0;
   logic [7:0] rdata;
   logic rvalid;
   logic overrun;
   logic acq_busy;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;

   adcst_host_model adcst_host_model_inst (.i_sys_clk(i_sys_clk), .o_io(io), .i_rdata(rdata), .i_rvalid(rvalid));
   adcst_status adcst_status_inst (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_io(io), .o_rdata(rdata),
      .o_rvalid(rvalid), .i_eng(eng), .i_avg_en(avg_en), .i_status_layout_select(layout),
      .i_polarity_jumper(pol), .i_wiring_jumper(wir), .i_fifo_superset_jumper(fifo_jmp),
      .o_overrun(overrun), .o_acq_reset_busy(acq_busy));

   initial begin
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic results();
      $display("mismatches %0d checks %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // generous ceiling; the sequence needs well under a thousand cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      adcst_host_model_inst.read(ADCST_STATUS_OFFSET, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, exp);
   endtask

   task automatic done_pulse();
      @(posedge i_sys_clk);
      eng.conv_done <= 1'b1;
      @(posedge i_sys_clk);
      eng.conv_done <= 1'b0;
   endtask

   // overrun is a one-cycle pulse, so it is looked at right after the trigger edge
   task automatic trig(input logic ov);
      @(posedge i_sys_clk);
      eng.trigger <= 1'b1;
      @(posedge i_sys_clk);
      eng.trigger <= 1'b0;
      #1;
      chk({7'h00, overrun}, {7'h00, ov});
   endtask

   initial begin
      logic [7:0] d;
      logic v;
      repeat (8) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      // the jumper synchronisers need two edges after release
      repeat (2) @(posedge i_sys_clk);
      rd(8'h40);
      @(posedge i_sys_clk);
      pol <= 1'b0;
      wir <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      rd(8'h20);
      done_pulse();
      rd(8'h30);
      trig(1'b1);
      rd(8'h31);
      adcst_host_model_inst.write(ADCST_STATUS_OFFSET, 4'h5);
      rd(8'h21);
      trig(1'b0);
      rd(8'h22);
      @(posedge i_sys_clk);
      fifo_jmp <= 1'b1;
      repeat (4) @(posedge i_sys_clk);
      done_pulse();
      trig(1'b0);
      @(posedge i_sys_clk);
      eng.fifo_full_flag <= 1'b1;
      trig(1'b1);
      eng.fifo_full_flag <= 1'b0;
      adcst_host_model_inst.write(ADCST_STATUS_OFFSET, 4'hA);
      eng.conv_busy <= 1'b1;
      rd(8'hA4);
      eng.conv_busy <= 1'b0;
      eng.scan_busy <= 1'b1;
      rd(8'hA4);
      eng.scan_busy <= 1'b0;
      layout <= 1'b1;
      eng.trigger_activity_config_bit <= 1'b1;
      eng.irq_src_b <= 1'b1;
      rd(8'h2A);
      eng <= '{fifo_irq: 1'b1, irq_src_a: 1'b1, default: 1'b0};
      rd(8'h25);
      layout <= 1'b0;
      eng <= '0;
      adcst_host_model_inst.write(ADCST_CHANNEL_OFFSET, 4'hF);
      // the busy output is the busy bit registered once more
      @(posedge i_sys_clk);
      #1;
      chk({7'h00, acq_busy}, 8'h01);
      rd(8'hAF);
      repeat (45) @(posedge i_sys_clk);
      rd(8'h2F);
      trig(1'b0);
      rd(8'h20);
      avg_en <= 1'b1;
      adcst_host_model_inst.write(ADCST_CHANNEL_OFFSET, 4'h3);
      repeat (300) @(posedge i_sys_clk);
      rd(8'hA3);
      repeat (110) @(posedge i_sys_clk);
      rd(8'h23);
      // reads at any other offset get no answer
      adcst_host_model_inst.read(4'h3, d, v);
      chk({7'h00, v}, 8'h00);
      // a completion in the same cycle as a clear leaves the flag set
      fork
         adcst_host_model_inst.write(ADCST_STATUS_OFFSET, 4'h0);
         done_pulse();
      join
      rd(8'h33);
      // reset in mid-run clears the pending flag and the channel index
      i_resetn <= 1'b0;
      repeat (4) @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      rd(8'h20);
      results();
   end
endmodule
